// ### hw/ipmc_bank.sv
`timescale 1ns/1ps
// What this block does
// [RULE_01] Rotate non-specific: clear top bit, make lowest
// [RULE_02] Rotate-auto mode rotates after second acknowledge
// [RULE_03] Separate set and clear for rotate-auto mode
// [RULE_04] Set priority moves pointer, keeps in-service bits
// [RULE_05] Rotate specific: clear named bit, make lowest
// [RULE_06] Nested: zero highest, plain end keeps order
// [RULE_07] Eight-bit mask, each bit masks one level
// [RULE_08] Mask gates latch output; masked requests still latch
// [RULE_09] Withdrawn masked request yields default vector
// [RULE_10] Special mask allows all unmasked, not in-service
// [RULE_11] Edge or level sensing, active-low inputs
// [RULE_12] Edge mode latches only falling transitions
// [RULE_13] Level requester withdraws before end command
// [RULE_14] Request must be low at first acknowledge
// [RULE_15] First acknowledge drives vector or zero
// [RULE_16] External logic captures cascade address
// [RULE_17] Software never programs zero slave vectors
// [RULE_18] Non-specific end clears highest in-service bit
// [RULE_19] Auto end clears top bit after second acknowledge
// [RULE_20] In-service blocks same and lower priority
// [RULE_21] Three-bit lowest pointer, resets to seven
// [RULE_22] Pointer and in-service bit update together
module ipmc_bank (
   // Clock, reset, enable
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic CLK_EN_I,
   // Request pins, active low
   input wire logic [7:0] IRQ_B_I,
   // Configuration
   input wire logic LEVEL_MODE_I,
   input wire logic [7:0] SLAVE_MAP_I,
   input wire logic [7:0][7:0] VECTOR_I,
   // Host commands and mask access
   input wire ipmc_pkg::ipmc_cmd_req_t CMD_I,
   input wire logic MASK_WE_I,
   input wire logic [7:0] MASK_DATA_I,
   // Acknowledge cycles
   input wire logic ACK1_I,
   input wire logic ACK2_I,
   // Results
   output logic INT_O,
   output logic [7:0] DATA_O,
   output logic DATA_OE_O,
   output logic DEFAULT_O,
   output logic [2:0] SVC_LEVEL_O,
   output logic [7:0] MASK_O,
   output logic [7:0] REQUEST_O,
   output logic [7:0] IN_SERVICE_O,
   output logic [2:0] LOWEST_O
);

   ipmc_pkg::ipmc_state_t r_q;
   ipmc_pkg::ipmc_state_t r_d;
   logic [7:0] fall;
   logic [7:0] pend;
   logic win_found;
   logic [2:0] win_lvl;
   logic isr_found;
   logic [2:0] isr_top;
   logic allowed;

   // Rank zero is the highest priority under the current rotation
   function automatic logic [2:0] ipmc_rank(input logic [2:0] lvl, input logic [2:0] low);
      ipmc_rank = lvl - low - ipmc_pkg::IPMC_RANK_STEP;
   endfunction : ipmc_rank

   // Falling edge of the synchronised pin, and eligible requests
   assign fall = r_q.prev & ~r_q.sync2; // [RULE_12]
   // Still-low check drops withdrawn requests, so the acknowledge gets the default
   assign pend = r_q.request_latch & ~r_q.request_mask & ~r_q.sync2 // [RULE_08] [RULE_14]
      & (r_q.special_mask ? ~r_q.in_service_bits : 8'hff); // [RULE_10]

   ipmc_prio_pick u_req_pick (
      .vec_i(pend),
      .lowest_i(r_q.lowest),
      .found_o(win_found),
      .level_o(win_lvl)
   );

   ipmc_prio_pick u_isr_pick (
      .vec_i(r_q.in_service_bits),
      .lowest_i(r_q.lowest),
      .found_o(isr_found),
      .level_o(isr_top)
   );

   // Winner must outrank every level in service unless special mask is on
   assign allowed = win_found && (r_q.special_mask || !isr_found // [RULE_20]
      || (ipmc_rank(win_lvl, r_q.lowest) < ipmc_rank(isr_top, r_q.lowest)));

   // Next state
   always_comb begin
      r_d = r_q;
      r_d.sync1 = IRQ_B_I;
      r_d.sync2 = r_q.sync1;
      r_d.prev = r_q.sync2;
      if (MASK_WE_I) begin
         r_d.request_mask = MASK_DATA_I; // [RULE_07]
      end
      if (CMD_I.valid) begin
         unique case (CMD_I.op)
            ipmc_pkg::IPMC_CMD_EOI_NS: begin
               if (isr_found) r_d.in_service_bits[isr_top] = 1'b0; // [RULE_18] [RULE_06]
            end
            ipmc_pkg::IPMC_CMD_EOI_SPEC: begin
               r_d.in_service_bits[CMD_I.level] = 1'b0;
            end
            ipmc_pkg::IPMC_CMD_ROT_NS: begin
               if (isr_found) begin
                  r_d.in_service_bits[isr_top] = 1'b0; // [RULE_01]
                  r_d.lowest = isr_top; // [RULE_22]
               end
            end
            ipmc_pkg::IPMC_CMD_ROT_SPEC: begin
               r_d.in_service_bits[CMD_I.level] = 1'b0; // [RULE_05]
               r_d.lowest = CMD_I.level; // [RULE_22]
            end
            ipmc_pkg::IPMC_CMD_SET_PRIO: r_d.lowest = CMD_I.level; // [RULE_04]
            ipmc_pkg::IPMC_CMD_ROT_AUTO_SET: r_d.rot_auto = 1'b1; // [RULE_03]
            ipmc_pkg::IPMC_CMD_ROT_AUTO_CLR: r_d.rot_auto = 1'b0; // [RULE_03]
            ipmc_pkg::IPMC_CMD_AUTO_SET: r_d.auto_eos = 1'b1;
            ipmc_pkg::IPMC_CMD_AUTO_CLR: r_d.auto_eos = 1'b0;
            ipmc_pkg::IPMC_CMD_SMM_SET: r_d.special_mask = 1'b1; // [RULE_10]
            ipmc_pkg::IPMC_CMD_SMM_CLR: r_d.special_mask = 1'b0; // [RULE_10]
            default: ;
         endcase
      end
      // Second acknowledge releases the bus and runs the automatic end
      if (ACK2_I) begin
         r_d.data_oe = 1'b0;
         if ((r_q.auto_eos || r_q.rot_auto) && isr_found) begin
            r_d.in_service_bits[isr_top] = 1'b0; // [RULE_19] [RULE_02]
            if (r_q.rot_auto) r_d.lowest = isr_top; // [RULE_02] [RULE_22]
         end
      end
      // Serviced edge request leaves the latch; level mode just follows the pin
      if (ACK1_I) begin
         r_d.data_oe = 1'b1;
         if (allowed) begin
            r_d.in_service_bits[win_lvl] = 1'b1;
            r_d.request_latch[win_lvl] = 1'b0;
            r_d.svc_level = win_lvl;
            r_d.dflt = 1'b0;
            r_d.data = SLAVE_MAP_I[win_lvl] ? VECTOR_I[win_lvl] // [RULE_15]
               : ipmc_pkg::IPMC_NONSLAVE_CODE;
         end else begin
            r_d.svc_level = ipmc_pkg::IPMC_DEFAULT_LEVEL; // [RULE_14] [RULE_09]
            r_d.dflt = 1'b1;
            r_d.data = ipmc_pkg::IPMC_NONSLAVE_CODE;
         end
      end
      // Set wins over the acknowledge clear, so a new edge is never lost
      if (LEVEL_MODE_I) begin
         r_d.request_latch = ~r_q.sync2; // [RULE_11]
      end else begin
         r_d.request_latch = r_d.request_latch | fall; // [RULE_11] [RULE_12]
      end
      r_d.int_req = allowed;
   end

   // State register; enable low freezes everything
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         r_q <= '0;
         r_q.sync1 <= ipmc_pkg::IPMC_PIN_IDLE;
         r_q.sync2 <= ipmc_pkg::IPMC_PIN_IDLE;
         r_q.prev <= ipmc_pkg::IPMC_PIN_IDLE;
         r_q.request_mask <= ipmc_pkg::IPMC_MASK_RESET;
         r_q.in_service_bits <= ipmc_pkg::IPMC_BITS_RESET;
         r_q.lowest <= ipmc_pkg::IPMC_PTR_RESET; // [RULE_21] [RULE_06]
      end else if (CLK_EN_I) begin
         r_q <= r_d;
      end
   end

   // Outputs straight from the state register
   assign INT_O = r_q.int_req;
   assign DATA_O = r_q.data;
   assign DATA_OE_O = r_q.data_oe;
   assign DEFAULT_O = r_q.dflt;
   assign SVC_LEVEL_O = r_q.svc_level;
   assign MASK_O = r_q.request_mask;
   assign REQUEST_O = r_q.request_latch;
   assign IN_SERVICE_O = r_q.in_service_bits;
   assign LOWEST_O = r_q.lowest;

   // Checks on the bank's own behaviour
   property p_rot_ns;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && CMD_I.valid && CMD_I.op == ipmc_pkg::IPMC_CMD_ROT_NS && isr_found
         && !ACK1_I && !ACK2_I
      |=> r_q.lowest == $past(isr_top) && !r_q.in_service_bits[$past(isr_top)];
   endproperty
   a_rot_ns: assert property (p_rot_ns) else $error("rotate non-specific wrong"); // [RULE_01]

   property p_rot_auto;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && ACK2_I && r_q.rot_auto && isr_found && !CMD_I.valid && !ACK1_I
      |=> r_q.lowest == $past(isr_top) && !r_q.in_service_bits[$past(isr_top)];
   endproperty
   a_rot_auto: assert property (p_rot_auto) else $error("auto rotation missed"); // [RULE_02]

   property p_set_prio;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && CMD_I.valid && CMD_I.op == ipmc_pkg::IPMC_CMD_SET_PRIO && !ACK1_I && !ACK2_I
      |=> r_q.lowest == $past(CMD_I.level) && $stable(r_q.in_service_bits);
   endproperty
   a_set_prio: assert property (p_set_prio) else $error("set priority wrong"); // [RULE_04]

   property p_rot_spec;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && CMD_I.valid && CMD_I.op == ipmc_pkg::IPMC_CMD_ROT_SPEC && !ACK1_I && !ACK2_I
      |=> r_q.lowest == $past(CMD_I.level) && !r_q.in_service_bits[$past(CMD_I.level)];
   endproperty
   a_rot_spec: assert property (p_rot_spec) else $error("rotate specific wrong"); // [RULE_05]

   property p_edge_only;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && !LEVEL_MODE_I && fall == 8'h00
      |=> (r_q.request_latch & ~$past(r_q.request_latch)) == 8'h00;
   endproperty
   a_edge_only: assert property (p_edge_only) else $error("latch set without edge"); // [RULE_12]

   property p_masked_latch;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && !LEVEL_MODE_I && fall != 8'h00
      |=> (r_q.request_latch & $past(fall)) == $past(fall);
   endproperty
   a_masked_latch: assert property (p_masked_latch) else $error("edge not latched"); // [RULE_08]

   property p_default;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && ACK1_I && !allowed
      |=> DEFAULT_O && DATA_OE_O && DATA_O == 8'h00 && SVC_LEVEL_O == 3'h7;
   endproperty
   a_default: assert property (p_default) else $error("default vector missing"); // [RULE_14]

   property p_cascade;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && ACK1_I && allowed
      |=> DATA_O == ($past(SLAVE_MAP_I[win_lvl]) ? $past(VECTOR_I[win_lvl]) : 8'h00)
         && r_q.in_service_bits[$past(win_lvl)] && !DEFAULT_O;
   endproperty
   a_cascade: assert property (p_cascade) else $error("cascade data wrong"); // [RULE_15]

   property p_block_lower;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      allowed && !r_q.special_mask && isr_found
      |-> !r_q.in_service_bits[win_lvl]
         && ipmc_rank(win_lvl, r_q.lowest) < ipmc_rank(isr_top, r_q.lowest);
   endproperty
   a_block_lower: assert property (p_block_lower) else $error("lower level not blocked"); // [RULE_20]

   property p_eos_ns;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
      CLK_EN_I && CMD_I.valid && CMD_I.op == ipmc_pkg::IPMC_CMD_EOI_NS && !ACK1_I && !ACK2_I
      |=> $stable(r_q.lowest);
   endproperty
   a_eos_ns: assert property (p_eos_ns) else $error("plain end moved priority"); // [RULE_06]

endmodule : ipmc_bank

// ### hw/ipmc_pkg.sv
package ipmc_pkg;

   // Bank geometry and reset values
   localparam int unsigned IPMC_LEVELS = 8;
   localparam logic [2:0] IPMC_PTR_RESET = 3'h7;
   localparam logic [7:0] IPMC_MASK_RESET = 8'h00;
   localparam logic [7:0] IPMC_BITS_RESET = 8'h00;
   localparam logic [7:0] IPMC_PIN_IDLE = 8'hff;
   localparam logic [7:0] IPMC_NONSLAVE_CODE = 8'h00;
   localparam logic [2:0] IPMC_DEFAULT_LEVEL = 3'h7;
   localparam logic [2:0] IPMC_RANK_STEP = 3'h1;

   // Commands of one bank
   typedef enum logic [3:0] {
      IPMC_CMD_EOI_NS       = 4'h0,
      IPMC_CMD_EOI_SPEC     = 4'h1,
      IPMC_CMD_ROT_NS       = 4'h2,
      IPMC_CMD_ROT_SPEC     = 4'h3,
      IPMC_CMD_SET_PRIO     = 4'h4,
      IPMC_CMD_ROT_AUTO_SET = 4'h5,
      IPMC_CMD_ROT_AUTO_CLR = 4'h6,
      IPMC_CMD_AUTO_SET     = 4'h7,
      IPMC_CMD_AUTO_CLR     = 4'h8,
      IPMC_CMD_SMM_SET      = 4'h9,
      IPMC_CMD_SMM_CLR      = 4'ha
   } ipmc_cmd_t;

   // One command request from the host
   typedef struct packed {
      logic valid;
      ipmc_cmd_t op;
      logic [2:0] level;
   } ipmc_cmd_req_t;

   // Whole state of the bank
   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] prev;
      logic [7:0] request_latch;
      logic [7:0] in_service_bits;
      logic [7:0] request_mask;
      logic [2:0] lowest;
      logic auto_eos;
      logic rot_auto;
      logic special_mask;
      logic int_req;
      logic [7:0] data;
      logic data_oe;
      logic dflt;
      logic [2:0] svc_level;
   } ipmc_state_t;

endpackage : ipmc_pkg

// ### hw/ipmc_prio_pick.sv
`timescale 1ns/1ps
// Picks the highest-priority set bit; the level after the lowest pointer wins
module ipmc_prio_pick (
   // Candidates and rotation pointer
   input wire logic [7:0] vec_i,
   input wire logic [2:0] lowest_i,
   // Result
   output logic found_o,
   output logic [2:0] level_o
);

   // Walk from lowest rank upward so the highest-priority hit is written last
   always_comb begin
      logic [2:0] idx;
      idx = 3'h0;
      found_o = 1'b0;
      level_o = 3'h0;
      for (int i = ipmc_pkg::IPMC_LEVELS - 1; i >= 0; i--) begin
         idx = lowest_i + ipmc_pkg::IPMC_RANK_STEP + 3'(i);
         if (vec_i[idx]) begin
            found_o = 1'b1;
            level_o = idx;
         end
      end
   end

endmodule : ipmc_prio_pick

// ### verif/ipmc_host_model.sv
`timescale 1ns/1ps
// Host side: runs both acknowledge cycles and latches the cascade address
module ipmc_host_model (
   // Clock and request from the bench
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [1:0] gap_i,
   // Bank side
   input wire logic [7:0] data_i,
   input wire logic data_oe_i,
   output logic ack1_o,
   output logic ack2_o,
   output logic done_o,
   output logic [7:0] cas_o
);
   // Pulses move at falling edges; a slow host stretches the gap between them
   initial begin
      ack1_o = 1'b0;
      ack2_o = 1'b0;
      done_o = 1'b0;
      cas_o = 8'h00;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            @(negedge clk_i);
            ack1_o = 1'b1;
            @(negedge clk_i);
            ack1_o = 1'b0;
            repeat (gap_i) @(negedge clk_i);
            // A bus not driven reads as garbage, never as the last value
            cas_o = data_oe_i ? data_i : ~data_i;
            ack2_o = 1'b1;
            @(negedge clk_i);
            ack2_o = 1'b0;
            done_o = 1'b1;
            @(negedge clk_i);
            done_o = 1'b0;
         end
      end
   end
endmodule : ipmc_host_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
// Random traffic on one bank, checked against a reference model
module tb_top;
   logic clk, rst_b, en, lvl, mwe, go, a1, a2, done, int_o, oe, dflt;
   logic [1:0] gap;
   logic [7:0] pins, smap, mdat, cas, mask_o, req_o, isv_o, dat, m_lat, m_isr, m_msk;
   logic [7:0][7:0] vec;
   logic [2:0] svc, low_o, m_low;
   logic m_auto, m_rot, m_smm;
   ipmc_pkg::ipmc_cmd_req_t cmd;
   int seed = 87015;
   int fail_count = 0;
   int check_count = 0;
   int w;
   // Set when the host never finishes an acknowledge; stops further steps
   int hung = 0;

   ipmc_bank i_dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .CLK_EN_I(en), .IRQ_B_I(pins),
      .LEVEL_MODE_I(lvl), .SLAVE_MAP_I(smap), .VECTOR_I(vec), .CMD_I(cmd), .MASK_WE_I(mwe),
      .MASK_DATA_I(mdat), .ACK1_I(a1), .ACK2_I(a2), .INT_O(int_o), .DATA_O(dat),
      .DATA_OE_O(oe), .DEFAULT_O(dflt), .SVC_LEVEL_O(svc), .MASK_O(mask_o),
      .REQUEST_O(req_o), .IN_SERVICE_O(isv_o), .LOWEST_O(low_o));
   ipmc_host_model i_host (.clk_i(clk), .go_i(go), .gap_i(gap), .data_i(dat),
      .data_oe_i(oe), .ack1_o(a1), .ack2_o(a2), .done_o(done), .cas_o(cas));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // First set bit after the lowest pointer; a set stop bit blocks the search
   function automatic int pick(logic [7:0] v, logic [7:0] stop, logic [2:0] lo);
      int l;
      for (int k = 1; k <= 8; k++) begin
         l = (lo + k) % 8;
         if (stop[l]) return -1;
         if (v[l]) return l;
      end
      return -1;
   endfunction : pick

   // Level that would win now, or -1
   function automatic int win();
      logic [7:0] c;
      c = m_lat & ~m_msk & ~pins;
      if (m_smm) return pick(c & ~m_isr, 8'h00, m_low);
      return pick(c, m_isr, m_low);
   endfunction : win

   task automatic tick(int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic chk(logic [7:0] got, logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic cmp_all();
      w = win();
      chk(req_o, m_lat);
      chk(isv_o, m_isr);
      chk(mask_o, m_msk);
      chk({5'h00, low_o}, {5'h00, m_low});
      chk({7'h00, int_o}, {7'h00, w >= 0});
   endtask : cmp_all

   task automatic do_reset();
      rst_b = 1'b0;
      pins = 8'hff;
      tick(12);
      {m_lat, m_isr, m_msk, m_auto, m_rot, m_smm} = '0;
      m_low = 3'h7;
      rst_b = 1'b1;
      tick(2);
   endtask : do_reset

   // One random operation, then a full comparison once everything has settled
   task automatic step();
      logic [31:0] r;
      logic [7:0] e;
      int h;
      int o;
      logic ok;
      r = $random(seed);
      ok = r[31:29] != 3'h0;
      h = pick(m_isr, 8'h00, m_low);
      case (r[1:0])
         2'h0: begin
            e = pins ^ (8'h01 << r[10:8]);
            m_lat = lvl ? ~e : m_lat | (pins & ~e);
            pins = e;
            tick(4);
         end
         2'h1: begin
            mdat = r[15:8] & r[23:16];
            mwe = 1'b1;
            en = ok;
            tick(1);
            {mwe, en} = 2'b01;
            if (ok) m_msk = mdat;
            tick(3);
         end
         2'h2: begin
            if (lvl && m_isr != 8'h00) begin
               pins = pins | m_isr;
               m_lat = ~pins;
               tick(4);
            end
            o = int'(r[11:8]) % 11;
            cmd = '{1'b1, ipmc_pkg::ipmc_cmd_t'(o), r[14:12]};
            en = ok;
            tick(1);
            cmd.valid = 1'b0;
            en = 1'b1;
            if (ok) begin
               case (o)
                  0: if (h >= 0) m_isr[h] = 1'b0;
                  1: m_isr[r[14:12]] = 1'b0;
                  2: if (h >= 0) {m_isr[h], m_low} = {1'b0, 3'(h)};
                  3: {m_isr[r[14:12]], m_low} = {1'b0, r[14:12]};
                  4: m_low = r[14:12];
                  5, 6: m_rot = o == 5;
                  7, 8: m_auto = o == 7;
                  9, 10: m_smm = o == 9;
                  default: ;
               endcase
            end
            tick(3);
         end
         default: begin
            gap = r[9:8];
            w = win();
            go = 1'b1;
            tick(1);
            go = 1'b0;
            for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk);
            if (done !== 1'b1) begin
               fail_count++;
               hung = 1;
               return;
            end
            e = 8'h00;
            if (w >= 0) begin
               m_isr[w] = 1'b1;
               if (!lvl) m_lat[w] = 1'b0;
               e = smap[w] ? vec[w] : 8'h00;
            end
            h = pick(m_isr, 8'h00, m_low);
            if ((m_auto || m_rot) && h >= 0) m_isr[h] = 1'b0;
            if (m_rot && h >= 0) m_low = 3'(h);
            tick(3);
            chk(cas, e);
            chk({7'h00, dflt}, {7'h00, w < 0});
            chk({5'h00, svc}, w < 0 ? 8'h07 : 8'(w));
            chk({7'h00, oe}, 8'h00);
         end
      endcase
      cmp_all();
   endtask : step

   // Edge phase, then level phase, each from a fresh reset
   initial begin
      {en, lvl, mwe, go, gap, mdat, rst_b} = {1'b1, 14'h0000};
      cmd = '0;
      pins = 8'hff;
      smap = 8'($random(seed));
      for (int n = 0; n < 8; n++) vec[n] = 8'($random(seed)) | 8'h01;
      for (int ph = 0; ph < 2 && hung == 0; ph++) begin
         lvl = ph[0];
         do_reset();
         cmp_all();
         repeat (500) if (hung == 0) step();
         $display("Phase %0d finished", ph);
      end
      conclude();
   end
endmodule : tb_top
